// ===== pac_classifier.sv
// pac_classifier: address word to subscriber address conversion and range classification
// assumes req comes from logic on clk; two-stage pipeline, both stages held while ce is low
`timescale 1ns/1ps
module pac_classifier
  import pac_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire pac_pkg::pac_req_t req,
  output pac_pkg::pac_rsp_t rsp
);

  logic vld1_r;
  logic [ADDR_W-1:0] addr1_r;
  logic [ADDR_W-1:0] addr1_nxt;
  pac_rsp_t rsp_r;

  // range lookup over contiguous bands
  function automatic pac_cat_t classify(input logic [ADDR_W-1:0] v);
    pac_cat_t c;
    if (v <= UB_ILLEGAL_ZERO) c = CAT_ILLEGAL;
    else if (v <= UB_SHORT) c = CAT_SHORT;
    else if (v <= UB_ILLEGAL_LO) c = CAT_ILLEGAL;
    else if (v <= UB_RSV_LO) c = CAT_RESERVED;
    else if (v <= UB_INFO_SVC) c = CAT_INFO_SVC;
    else if (v <= UB_NETWORK) c = CAT_NETWORK;
    else if (v <= UB_TEMPORARY) c = CAT_TEMPORARY;
    else if (v <= UB_OPERATOR) c = CAT_OPERATOR;
    else if (v <= UB_RSV_MID) c = CAT_RESERVED;
    else if (v <= UB_ILLEGAL_HI) c = CAT_ILLEGAL;
    else if (v <= UB_L12_UNCOORD) c = CAT_L12_UNCOORD;
    else if (v <= UB_L12_COUNTRY) c = CAT_L12_COUNTRY;
    else if (v <= UB_L12_GLOBAL) c = CAT_L12_GLOBAL;
    else if (v <= UB_L13_GLOBAL) c = CAT_L13_GLOBAL;
    else if (v <= UB_L14_GLOBAL) c = CAT_L14_GLOBAL;
    else if (v <= UB_L23_COUNTRY) c = CAT_L23_COUNTRY;
    else if (v <= UB_L23_RESERVED) c = CAT_L23_RESERVED;
    else if (v <= UB_L23_INFO_GLB) c = CAT_L23_INFO_GLB;
    else if (v <= UB_L23_INFO_CTY) c = CAT_L23_INFO_CTY;
    else if (v <= UB_L23_INFO_WW) c = CAT_L23_INFO_WW;
    else if (v <= UB_RSV_TOP) c = CAT_RESERVED;
    else c = CAT_UNDEFINED;
    return c;
  endfunction

  // long pair to address value
  function automatic logic [ADDR_W-1:0] long_value(
    input logic [WORD_W-1:0] w1,
    input logic [WORD_W-1:0] w2
  );
    logic [ADDR_W-1:0] hi;
    hi = ADDR_W'({~w2, LONG_SHIFT'(0)});
    return hi + LONG_BASE + ADDR_W'(w1);
  endfunction

  // stage one: word to value conversion
  always_comb
  begin
    case (req.op)
      OP_SHORT: addr1_nxt = ADDR_W'(req.word1) - SHORT_OFFSET;
      OP_LONG: addr1_nxt = long_value(req.word1, req.word2);
      default: addr1_nxt = req.value;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      vld1_r <= 1'b0;
      addr1_r <= '0;
    end
    else if (ce)
    begin
      vld1_r <= req.valid;
      if (req.valid)
        addr1_r <= addr1_nxt;
    end
  end

  // stage two: category lookup
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rsp_r <= '{valid: 1'b0, subscriber_address_code: '0, category: CAT_ILLEGAL};
    end
    else if (ce)
    begin
      rsp_r.valid <= vld1_r;
      if (vld1_r)
      begin
        rsp_r.subscriber_address_code <= addr1_r;
        rsp_r.category <= classify(addr1_r);
      end
    end
  end

  assign rsp = rsp_r;

  // checks
  property p_stage1(pac_op_t op, logic [ADDR_W-1:0] expv);
    @(posedge clk) disable iff (!rstn)
      (ce && req.valid && req.op == op) |=> (vld1_r && addr1_r == $past(expv));
  endproperty

  a_short_subtract: assert property (p_stage1(OP_SHORT,
    ADDR_W'(req.word1) - SHORT_OFFSET))
    else $error("short address value wrong");

  a_long_complement: assert property (p_stage1(OP_LONG,
    ADDR_W'(37'h1fffff - ADDR_W'(req.word2)) * 37'h8000 + LONG_BASE + ADDR_W'(req.word1)))
    else $error("long address value wrong");

  a_long_base: assert property (@(posedge clk) disable iff (!rstn)
    (ce && req.valid && req.op == OP_LONG && req.word1 == '0 && (&req.word2))
    |=> addr1_r == LONG_BASE)
    else $error("long base offset wrong");

  a_l12_ranges: assert property (@(posedge clk) disable iff (!rstn)
    rsp_r.valid && rsp_r.subscriber_address_code > UB_ILLEGAL_HI
    && rsp_r.subscriber_address_code <= UB_L12_UNCOORD |-> rsp_r.category == CAT_L12_UNCOORD)
    else $error("uncoordinated set 1-2 misclassified");

  a_l12_country: assert property (@(posedge clk) disable iff (!rstn)
    rsp_r.valid && rsp_r.category == CAT_L12_COUNTRY
    |-> rsp_r.subscriber_address_code >= 37'h000615f103
    && rsp_r.subscriber_address_code <= 37'h0017f79402)
    else $error("country set 1-2 bounds wrong");

  a_l12_global: assert property (@(posedge clk) disable iff (!rstn)
    rsp_r.valid && rsp_r.category == CAT_L12_GLOBAL
    |-> rsp_r.subscriber_address_code >= 37'h0017f79403
    && rsp_r.subscriber_address_code <= 37'h0040201000)
    else $error("global set 1-2 bounds wrong");

  a_l13_l14: assert property (@(posedge clk) disable iff (!rstn)
    rsp_r.valid && (rsp_r.category == CAT_L13_GLOBAL || rsp_r.category == CAT_L14_GLOBAL)
    |-> rsp_r.subscriber_address_code > 37'h0040201000
    && rsp_r.subscriber_address_code <= 37'h00c0201000)
    else $error("set 1-3 or 1-4 bounds wrong");

  a_l23_bands: assert property (@(posedge clk) disable iff (!rstn)
    rsp_r.valid && rsp_r.category >= CAT_L23_COUNTRY && rsp_r.category <= CAT_L23_INFO_WW
    |-> rsp_r.subscriber_address_code > 37'h00c0201000
    && rsp_r.subscriber_address_code <= 37'h00ffc376c0)
    else $error("set 2-3 bounds wrong");

  a_undef_top: assert property (@(posedge clk) disable iff (!rstn)
    rsp_r.valid && rsp_r.subscriber_address_code > 37'h0100200ffe
    |-> rsp_r.category == CAT_UNDEFINED)
    else $error("out of range value not undefined");

  a_low_bands: assert property (@(posedge clk) disable iff (!rstn)
    rsp_r.valid && rsp_r.subscriber_address_code <= 37'h0000201000
    |-> rsp_r.category inside {CAT_ILLEGAL, CAT_SHORT, CAT_RESERVED, CAT_INFO_SVC,
      CAT_NETWORK, CAT_TEMPORARY, CAT_OPERATOR})
    else $error("low band misclassified");

  a_pipe_latency: assert property (@(posedge clk) disable iff (!rstn)
    ce && req.valid ##1 ce [*1] |=> rsp_r.valid)
    else $error("result not two stages later");

  c_short: cover property (@(posedge clk) disable iff (!rstn)
    rsp_r.valid && rsp_r.category == CAT_SHORT);
  c_long12: cover property (@(posedge clk) disable iff (!rstn)
    rsp_r.valid && rsp_r.category == CAT_L12_GLOBAL);
  c_undef: cover property (@(posedge clk) disable iff (!rstn)
    rsp_r.valid && rsp_r.category == CAT_UNDEFINED);
  c_stall: cover property (@(posedge clk) disable iff (!rstn)
    vld1_r && !ce);

endmodule

// ===== pac_pkg.sv
// pac_pkg: constants and types for the pager address classifier
// assumes one clock domain; users import pac_pkg::*
package pac_pkg;

  localparam int WORD_W = 21;
  localparam int ADDR_W = 37;
  localparam int LONG_SHIFT = 15;

  localparam logic [ADDR_W-1:0] SHORT_OFFSET = 37'h0000008000;
  localparam logic [ADDR_W-1:0] LONG_BASE = 37'h00001f9000;

  // upper bounds of the contiguous assignment ranges
  localparam logic [ADDR_W-1:0] UB_ILLEGAL_ZERO = 37'h0000000000;
  localparam logic [ADDR_W-1:0] UB_SHORT = 37'h00001d8000;
  localparam logic [ADDR_W-1:0] UB_ILLEGAL_LO = 37'h00001e8000;
  localparam logic [ADDR_W-1:0] UB_RSV_LO = 37'h00001ea7ff;
  localparam logic [ADDR_W-1:0] UB_INFO_SVC = 37'h00001ee7ff;
  localparam logic [ADDR_W-1:0] UB_NETWORK = 37'h00001ef7ff;
  localparam logic [ADDR_W-1:0] UB_TEMPORARY = 37'h00001ef80f;
  localparam logic [ADDR_W-1:0] UB_OPERATOR = 37'h00001ef81f;
  localparam logic [ADDR_W-1:0] UB_RSV_MID = 37'h00001efffe;
  localparam logic [ADDR_W-1:0] UB_ILLEGAL_HI = 37'h0000201000;
  localparam logic [ADDR_W-1:0] UB_L12_UNCOORD = 37'h000615f102;
  localparam logic [ADDR_W-1:0] UB_L12_COUNTRY = 37'h0017f79402;
  localparam logic [ADDR_W-1:0] UB_L12_GLOBAL = 37'h0040201000;
  localparam logic [ADDR_W-1:0] UB_L13_GLOBAL = 37'h0080201000;
  localparam logic [ADDR_W-1:0] UB_L14_GLOBAL = 37'h00c0201000;
  localparam logic [ADDR_W-1:0] UB_L23_COUNTRY = 37'h00e9d9371e;
  localparam logic [ADDR_W-1:0] UB_L23_RESERVED = 37'h00ff1b9e00;
  localparam logic [ADDR_W-1:0] UB_L23_INFO_GLB = 37'h00ff67e940;
  localparam logic [ADDR_W-1:0] UB_L23_INFO_CTY = 37'h00ffb43480;
  localparam logic [ADDR_W-1:0] UB_L23_INFO_WW = 37'h00ffc376c0;
  localparam logic [ADDR_W-1:0] UB_RSV_TOP = 37'h0100200ffe;

  typedef enum logic [1:0] {
    OP_SHORT = 2'h0,
    OP_LONG = 2'h1,
    OP_CLASSIFY = 2'h2
  } pac_op_t;

  typedef enum logic [4:0] {
    CAT_ILLEGAL = 5'h00,
    CAT_SHORT = 5'h01,
    CAT_RESERVED = 5'h02,
    CAT_INFO_SVC = 5'h03,
    CAT_NETWORK = 5'h04,
    CAT_TEMPORARY = 5'h05,
    CAT_OPERATOR = 5'h06,
    CAT_L12_UNCOORD = 5'h07,
    CAT_L12_COUNTRY = 5'h08,
    CAT_L12_GLOBAL = 5'h09,
    CAT_L13_GLOBAL = 5'h0a,
    CAT_L14_GLOBAL = 5'h0b,
    CAT_L23_COUNTRY = 5'h0c,
    CAT_L23_RESERVED = 5'h0d,
    CAT_L23_INFO_GLB = 5'h0e,
    CAT_L23_INFO_CTY = 5'h0f,
    CAT_L23_INFO_WW = 5'h10,
    CAT_UNDEFINED = 5'h11
  } pac_cat_t;

  typedef struct packed {
    logic valid;
    pac_op_t op;
    logic [WORD_W-1:0] word1;
    logic [WORD_W-1:0] word2;
    logic [ADDR_W-1:0] value;
  } pac_req_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] subscriber_address_code;
    pac_cat_t category;
  } pac_rsp_t;

endpackage

// ===== pac_word_src.sv
// pac_word_src: stand-in for the decoder datapath that feeds address words
// assumes its fields come from the bench, changed just after a rising clk
`timescale 1ns/1ps
module pac_word_src
  import pac_pkg::*;
(
  input wire logic valid,
  input wire pac_pkg::pac_op_t op,
  input wire logic [pac_pkg::WORD_W-1:0] word1,
  input wire logic [pac_pkg::WORD_W-1:0] word2,
  input wire logic [pac_pkg::ADDR_W-1:0] value,
  output pac_pkg::pac_req_t req
);
  // word1 shows its inverse while valid is low, word2 unless valid with OP_LONG, not a stale value
  assign req = '{valid: valid, op: op, word1: valid ? word1 : ~word1,
                 word2: (valid && op == OP_LONG) ? word2 : ~word2, value: value};
endmodule

// ===== pac_classifier_bench.sv
// pac_classifier_bench: classifier against an integer and queue model
// assumes pac_pkg, pac_word_src and pac_classifier are compiled first
`timescale 1ns/1ps
module pac_classifier_bench;
  import pac_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic s_valid = 1'b0;
  pac_op_t s_op = OP_SHORT;
  logic [WORD_W-1:0] s_w1 = '0;
  logic [WORD_W-1:0] s_w2 = '0;
  logic [ADDR_W-1:0] s_val = '0;
  pac_req_t req;
  pac_rsp_t rsp;
  int n_errors = 0;
  int total_checks = 0;
  logic upd = 1'b0;
  logic [ADDR_W-1:0] q_code[$];
  pac_cat_t q_cat[$];
  longint ub[21] = '{0, 1933312, 1998848, 2009087, 2025471, 2029567, 2029583, 2029599,
    2031614, 2101248, 102101250, 402101250, 1075843072, 64'd2149584896, 64'd3223326720,
    64'd3923326750, 64'd4280000000, 64'd4285000000, 64'd4290000000, 64'd4291000000,
    64'd4297068542};
  pac_cat_t cats[21] = '{CAT_ILLEGAL, CAT_SHORT, CAT_ILLEGAL, CAT_RESERVED, CAT_INFO_SVC,
    CAT_NETWORK, CAT_TEMPORARY, CAT_OPERATOR, CAT_RESERVED, CAT_ILLEGAL, CAT_L12_UNCOORD,
    CAT_L12_COUNTRY, CAT_L12_GLOBAL, CAT_L13_GLOBAL, CAT_L14_GLOBAL, CAT_L23_COUNTRY,
    CAT_L23_RESERVED, CAT_L23_INFO_GLB, CAT_L23_INFO_CTY, CAT_L23_INFO_WW, CAT_RESERVED};
  always #10 clk = ~clk;
  pac_word_src u_pac_word_src (.valid(s_valid), .op(s_op), .word1(s_w1), .word2(s_w2),
    .value(s_val), .req(req));
  pac_classifier u_pac_classifier (.clk(clk), .rstn(rstn), .ce(ce), .req(req), .rsp(rsp));
  function automatic pac_cat_t exp_cat(longint v);
    foreach (ub[i])
      if (v <= ub[i])
        return cats[i];
    return CAT_UNDEFINED;
  endfunction
  task automatic chk(string name, logic [ADDR_W-1:0] seen, logic [ADDR_W-1:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    if (n_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic send(pac_op_t op, logic [WORD_W-1:0] w1, logic [WORD_W-1:0] w2,
                      logic [ADDR_W-1:0] v);
    @(posedge clk);
    #2;
    {s_valid, s_op, s_w1, s_w2, s_val} = {1'b1, op, w1, w2, v};
    ce = ($urandom % 4) != 0;
    if (!ce)
    begin
      @(posedge clk);
      #2;
      ce = 1'b1;
    end
  endtask
  // results counted once per enabled edge; requests queued as taken
  always @(negedge clk)
  begin
    longint c;
    pac_cat_t ec;
    if (upd && rsp.valid)
    begin
      if (q_code.size() == 0)
        chk("spurious valid", 37'h1, 37'h0);
      else
      begin
        ec = q_cat.pop_front();
        chk("code", rsp.subscriber_address_code, q_code.pop_front());
        if (ec <= CAT_OPERATOR)
          chk("low cat", ADDR_W'(rsp.category), ADDR_W'(ec));
        else if (ec <= CAT_L14_GLOBAL)
          chk("set1 cat", ADDR_W'(rsp.category), ADDR_W'(ec));
        else if (ec != CAT_UNDEFINED)
          chk("set2 cat", ADDR_W'(rsp.category), ADDR_W'(ec));
        else
          chk("undef cat", ADDR_W'(rsp.category), ADDR_W'(ec));
      end
    end
    upd = ce && rstn;
    if (ce && s_valid && rstn)
    begin
      if (s_op == OP_SHORT)
        c = longint'(s_w1) - 32768;
      else if (s_op == OP_LONG)
        c = (2097151 - longint'(s_w2)) * 32768 + 2068480 + longint'(s_w1);
      else
        c = longint'(s_val);
      c = c & 64'h1fffffffff;
      q_code.push_back(ADDR_W'(c));
      q_cat.push_back(exp_cat(c));
    end
  end
  initial
  begin
    #200000;
    n_errors++;
    close_out();
  end
  initial
  begin
    void'($urandom(32'haf5f));
    repeat (5) @(posedge clk);
    #2;
    rstn = 1'b1;
    foreach (ub[i])
    begin
      send(OP_CLASSIFY, '0, '0, ADDR_W'(ub[i]));
      send(OP_CLASSIFY, '0, '0, ADDR_W'(ub[i] + 1));
    end
    send(OP_SHORT, 21'h008001, '0, '0);
    send(OP_SHORT, 21'h008000, '0, '0);
    send(OP_SHORT, 21'h007fff, '0, '0);
    send(OP_LONG, 21'h000001, 21'h1fffff, '0);
    send(OP_LONG, 21'h1fffff, 21'h000000, '0);
    send(OP_LONG, 21'h000000, 21'h1fffff, '0);
    repeat (60)
      send(pac_op_t'($urandom % 4), WORD_W'($urandom), WORD_W'($urandom), ADDR_W'($urandom));
    @(posedge clk);
    #2;
    s_valid = 1'b0;
    ce = 1'b1;
    repeat (8) @(posedge clk);
    chk("pending", ADDR_W'(q_code.size()), '0);
    close_out();
  end
endmodule
